// ---- inc/link_enh_defines.svh ----
// Purpose: offsets, field positions, reset values and counts of the link enhancement control
// Assumes: 32-bit register, byte offsets as printed
// Notes:
// Notes on behaviour
// - two-bit threshold picks 2K, 1.7K (default), 1K or 512 byte start level
// - programmed threshold is used only until the first transmit FIFO underrun
// - a retried packet always uses the 2K threshold, store-and-forward
// - below 2K, start at threshold level or when whole packet checked in
// - after an underrun the link switches to store-and-forward for retransmission
// - with 2K selected nothing goes out before the end-of-packet token
// - a zero transmit retries register forces store-and-forward
// - mpeg stamp bit marks iso packets with tag 01 and format 10h
// - dv stamp bit marks dv cip streams with format 00h; resets to 0
// - priority enable bit makes requests use priority arbitration; resets to 0
// - phy drives 11b on control lines when link asks; link may then drive
// - idle enable bit inserts one idle clock before the link drives the lines
// - eeprom word 05h bit 2 loads the idle enable bit when present
// - acceleration bit tells the phy the link supports acceleration; resets 0
// - bits 11, 9, 6 to 3 and 0 always read as zero
// - marked bits return to defaults on fundamental or global reset
// - set alias sets written ones, clear alias clears written ones
`ifndef LINK_ENH_DEFINES_SVH
`define LINK_ENH_DEFINES_SVH
`define LEC_CFG_OFS       12'h0f4
`define LEC_SET_OFS       12'ha88
`define LEC_CLR_OFS       12'ha8c
`define LEC_RESET_VAL     32'h0000_1000
`define LEC_WR_MASK       32'h0000_f586
`define LEC_COLD_MASK     32'h0000_c586
`define LEC_BIT_PIPE_DIS  15
`define LEC_THR_HI        13
`define LEC_THR_LO        12
`define LEC_BIT_MPEG      10
`define LEC_BIT_DV        8
`define LEC_BIT_PRIO      7
`define LEC_BIT_IDLE      2
`define LEC_BIT_ACCEL     1
`define LEC_THR_SF        2'h0
`define LEC_THR_BYTES_SF  12'h800
`define LEC_THR_BYTES_17  12'h6cd
`define LEC_THR_BYTES_1K  12'h400
`define LEC_THR_BYTES_512 12'h200
`define LEC_EE_WORD       8'h05
`define LEC_EE_BIT        2
`define LEC_MPEG_TAG      2'h1
`define LEC_MPEG_FORMAT   6'h10
`define LEC_DV_FORMAT     6'h00
`define LEC_CTL_GRANT     2'h3
`endif

// ---- inc/link_enh_pkg.sv ----
// Purpose: types shared by the link enhancement control files
// Assumes: nothing beyond the defines header
// Notes: register requests and iso headers travel as packed structs
package link_enh_pkg;
  typedef struct packed {
    logic        cfg_space;
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] tag;
    logic [5:0] cip_format_field;
  } iso_hdr_s;

  typedef enum logic [1:0] {
    PHY_OWNS    = 2'b00,
    TURN_IDLE   = 2'b01,
    LINK_DRIVES = 2'b10
  } turn_state_e;

  typedef logic [11:0] fill_t;
endpackage

// ---- rtl/async_tx_gate.sv ----
// Purpose: start decision for asynchronous transmit
// Assumes: fill count in bytes, same clock as caller
// Notes: underrun memory held until reset
`timescale 1ns/1ns
`include "link_enh_defines.svh"
module async_tx_gate (
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic [1:0]           thresh_sel_in,
  input  wire logic                 retries_zero_in,
  input  wire logic                 retry_in,
  input  wire logic                 underrun_in,
  input  wire link_enh_pkg::fill_t  fill_bytes_in,
  input  wire logic                 pkt_checked_in,
  output logic                      store_fwd_out,
  output logic                      start_ok_out
);
  logic                underrun_seen_r;
  link_enh_pkg::fill_t thr_bytes;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) underrun_seen_r <= 1'b0;
    else if (underrun_in) underrun_seen_r <= 1'b1;
  end

  assign store_fwd_out = (thresh_sel_in == `LEC_THR_SF) | retries_zero_in | retry_in
                         | underrun_seen_r | underrun_in;
  assign thr_bytes = (thresh_sel_in == 2'h1) ? `LEC_THR_BYTES_17 :
                     (thresh_sel_in == 2'h2) ? `LEC_THR_BYTES_1K :
                     (thresh_sel_in == 2'h3) ? `LEC_THR_BYTES_512 : `LEC_THR_BYTES_SF;
  assign start_ok_out = pkt_checked_in | (!store_fwd_out && (fill_bytes_in >= thr_bytes));
endmodule

// ---- rtl/ctl_turnaround.sv ----
// Purpose: link ownership of the internal phy control and data lines
// Assumes: phy lines on the same clock, no synchronisers needed
// Notes: enables are active low
`timescale 1ns/1ns
`include "link_enh_defines.svh"
module ctl_turnaround (
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 idle_en_in,
  input  wire logic                 link_req_in,
  input  wire logic                 link_release_in,
  input  wire logic [1:0]           phy_ctl_in,
  output link_enh_pkg::turn_state_e state_out
);
  link_enh_pkg::turn_state_e state_r;
  link_enh_pkg::turn_state_e state_nxt;
  logic                      granted;

  assign granted = link_req_in && (phy_ctl_in == `LEC_CTL_GRANT);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      link_enh_pkg::PHY_OWNS: begin
        if (granted) state_nxt = idle_en_in ? link_enh_pkg::TURN_IDLE : link_enh_pkg::LINK_DRIVES;
      end
      link_enh_pkg::TURN_IDLE:   state_nxt = link_enh_pkg::LINK_DRIVES;
      link_enh_pkg::LINK_DRIVES: begin
        if (link_release_in) state_nxt = link_enh_pkg::PHY_OWNS;
      end
      default: state_nxt = link_enh_pkg::PHY_OWNS;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) state_r <= link_enh_pkg::PHY_OWNS;
    else state_r <= state_nxt;
  end

  assign state_out = state_r;
endmodule

// ---- rtl/link_enhancement_control.sv ----
// Purpose: link enhancement control register and the behaviour it steers
// Assumes: register port and phy lines on clk_in; reset pins are asynchronous
// Notes: the config alias is a plain write, the memory aliases set or clear
`timescale 1ns/1ns
`include "link_enh_defines.svh"
module link_enhancement_control (
  input  wire logic                   clk_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   fundamental_reset_b_in,
  input  wire logic                   global_reset_pin_b_in,
  input  wire link_enh_pkg::reg_req_s reg_req_in,
  output logic [31:0]                 reg_rdata_out,
  output logic                        reg_rvalid_out,
  input  wire logic                   eeprom_present_in,
  input  wire logic                   eeprom_word_valid_in,
  input  wire logic [7:0]             eeprom_word_addr_in,
  input  wire logic [15:0]            eeprom_word_in,
  input  wire logic                   retries_zero_in,
  input  wire logic                   async_transmit_retry_in,
  input  wire logic                   async_transmit_underrun_in,
  input  wire link_enh_pkg::fill_t    async_transmit_fill_in,
  input  wire logic                   async_transmit_pkt_done_in,
  output logic                        async_transmit_sf_out,
  output logic                        async_transmit_start_out,
  output logic                        async_pipeline_disable_out,
  input  wire link_enh_pkg::iso_hdr_s iso_hdr_in,
  output logic                        mpeg_stamp_apply_out,
  output logic                        dv_stamp_apply_out,
  input  wire logic                   async_req_in,
  output logic                        arb_priority_req_out,
  output logic                        arb_fair_req_out,
  output logic                        phy_accel_notice_out,
  input  wire logic                   link_req_ctl_in,
  input  wire logic                   link_release_in,
  input  wire logic [1:0]             ctl_tx_in,
  input  wire logic [8:0]             data_tx_in,
  input  wire logic [1:0]             phy_link_ctl_lines_in,
  output logic [1:0]                  phy_link_ctl_lines_out,
  output logic                        phy_link_ctl_lines_oe_b_out,
  input  wire logic [8:0]             phy_link_data_in,
  output logic [8:0]                  phy_link_data_out,
  output logic                        phy_link_data_oe_b_out,
  output logic [8:0]                  phy_link_data_rx_out
);
  logic [31:0]                 ctrl_r;
  logic [31:0]                 ctrl_nxt;
  logic [31:0]                 rdata_r;
  logic                        rvalid_r;
  logic [1:0]                  fund_sync_r;
  logic [1:0]                  glob_sync_r;
  logic                        cold_rst;
  logic                        cfg_hit;
  logic                        set_hit;
  logic                        clr_hit;
  logic                        mapped;
  logic [31:0]                 wbits;
  logic [31:0]                 after_cfg;
  logic [31:0]                 after_set;
  logic [31:0]                 after_clr;
  logic [31:0]                 after_ee;
  logic                        ee_hit;
  logic                        mpeg_match;
  logic                        dv_match;
  logic                        mpeg_r;
  logic                        dv_r;
  logic                        prio_r;
  logic                        fair_r;
  logic [1:0]                  ctl_r;
  logic [8:0]                  data_r;
  logic [8:0]                  data_rx_r;
  logic                        start_ok;
  logic                        store_fwd;
  link_enh_pkg::turn_state_e   turn_state;

  // reset pins pass two flops
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      fund_sync_r <= 2'h3;
      glob_sync_r <= 2'h3;
    end else begin
      fund_sync_r <= {fund_sync_r[0], fundamental_reset_b_in};
      glob_sync_r <= {glob_sync_r[0], global_reset_pin_b_in};
    end
  end

  assign cold_rst = !fund_sync_r[1] || !glob_sync_r[1];

  // address decode
  assign cfg_hit = reg_req_in.cfg_space && (reg_req_in.addr == `LEC_CFG_OFS);
  assign set_hit = !reg_req_in.cfg_space && (reg_req_in.addr == `LEC_SET_OFS);
  assign clr_hit = !reg_req_in.cfg_space && (reg_req_in.addr == `LEC_CLR_OFS);
  assign mapped  = cfg_hit || set_hit || clr_hit;
  assign wbits   = reg_req_in.wdata & `LEC_WR_MASK;

  assign after_cfg = (reg_req_in.wr && cfg_hit) ? wbits : ctrl_r;
  assign after_set = (reg_req_in.wr && set_hit) ? (after_cfg | wbits) : after_cfg;
  assign after_clr = (reg_req_in.wr && clr_hit) ? (after_set & ~wbits) : after_set;

  assign ee_hit   = eeprom_present_in && eeprom_word_valid_in
                    && (eeprom_word_addr_in == `LEC_EE_WORD);
  assign after_ee = ee_hit ? {after_clr[31:`LEC_BIT_IDLE + 1], eeprom_word_in[`LEC_EE_BIT],
                              after_clr[`LEC_BIT_IDLE - 1:0]} : after_clr;

  assign ctrl_nxt = cold_rst ? ((after_ee & ~`LEC_COLD_MASK) | (`LEC_RESET_VAL & `LEC_COLD_MASK))
                             : after_ee;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) ctrl_r <= `LEC_RESET_VAL;
    else ctrl_r <= ctrl_nxt;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= (reg_req_in.rd && mapped) ? (ctrl_r & `LEC_WR_MASK) : 32'h0000_0000;
      rvalid_r <= reg_req_in.rd;
    end
  end

  assign reg_rdata_out  = rdata_r;
  assign reg_rvalid_out = rvalid_r;

  async_tx_gate u_gate (
    .clk_in          (clk_in),
    .rst_b_in        (rst_b_in),
    .thresh_sel_in   (ctrl_r[`LEC_THR_HI:`LEC_THR_LO]),
    .retries_zero_in (retries_zero_in),
    .retry_in        (async_transmit_retry_in),
    .underrun_in     (async_transmit_underrun_in),
    .fill_bytes_in   (async_transmit_fill_in),
    .pkt_checked_in  (async_transmit_pkt_done_in),
    .store_fwd_out   (store_fwd),
    .start_ok_out    (start_ok)
  );

  assign async_transmit_sf_out      = store_fwd;
  assign async_transmit_start_out   = start_ok;
  assign async_pipeline_disable_out = ctrl_r[`LEC_BIT_PIPE_DIS];

  assign mpeg_match = iso_hdr_in.valid && ctrl_r[`LEC_BIT_MPEG]
                      && (iso_hdr_in.tag == `LEC_MPEG_TAG)
                      && (iso_hdr_in.cip_format_field == `LEC_MPEG_FORMAT);
  assign dv_match   = iso_hdr_in.valid && ctrl_r[`LEC_BIT_DV]
                      && (iso_hdr_in.cip_format_field == `LEC_DV_FORMAT);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mpeg_r <= 1'b0;
      dv_r   <= 1'b0;
    end else begin
      mpeg_r <= mpeg_match;
      dv_r   <= dv_match;
    end
  end

  assign mpeg_stamp_apply_out = mpeg_r;
  assign dv_stamp_apply_out   = dv_r;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      prio_r <= 1'b0;
      fair_r <= 1'b0;
    end else begin
      prio_r <= async_req_in && ctrl_r[`LEC_BIT_PRIO];
      fair_r <= async_req_in && !ctrl_r[`LEC_BIT_PRIO];
    end
  end

  assign arb_priority_req_out = prio_r;
  assign arb_fair_req_out     = fair_r;

  assign phy_accel_notice_out = ctrl_r[`LEC_BIT_ACCEL];

  ctl_turnaround u_turn (
    .clk_in          (clk_in),
    .rst_b_in        (rst_b_in),
    .idle_en_in      (ctrl_r[`LEC_BIT_IDLE]),
    .link_req_in     (link_req_ctl_in),
    .link_release_in (link_release_in),
    .phy_ctl_in      (phy_link_ctl_lines_in),
    .state_out       (turn_state)
  );

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ctl_r     <= 2'h0;
      data_r    <= 9'h000;
      data_rx_r <= 9'h000;
    end else begin
      ctl_r     <= ctl_tx_in;
      data_r    <= data_tx_in;
      data_rx_r <= phy_link_data_in;
    end
  end

  assign phy_link_ctl_lines_out      = ctl_r;
  assign phy_link_data_out           = data_r;
  assign phy_link_data_rx_out        = data_rx_r;
  assign phy_link_ctl_lines_oe_b_out = (turn_state != link_enh_pkg::LINK_DRIVES);
  assign phy_link_data_oe_b_out      = (turn_state != link_enh_pkg::LINK_DRIVES);

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_set_alias_ones: assert property (
    (reg_req_in.wr && set_hit && !cold_rst && !ee_hit) |=> ((ctrl_r & $past(wbits)) == $past(wbits))
  ) else $error("set alias did not set written ones");

  a_clr_alias_ones: assert property (
    (reg_req_in.wr && clr_hit && !ee_hit) |=> ((ctrl_r & $past(wbits)) == 32'h0000_0000)
  ) else $error("clear alias did not clear written ones");

  a_zero_bits_kept: assert property (
    (reg_req_in.wr && (set_hit || clr_hit) && !cold_rst && !ee_hit)
    |=> ((ctrl_r & ~$past(wbits)) == ($past(ctrl_r) & ~$past(wbits)))
  ) else $error("set or clear write disturbed a zero bit");

  a_read_returns_reg: assert property (
    (reg_req_in.rd && mapped) |=> (reg_rvalid_out && reg_rdata_out == ($past(ctrl_r) & `LEC_WR_MASK))
  ) else $error("read did not return register contents");

  a_reserved_zero: assert property (
    reg_rvalid_out |-> ((reg_rdata_out & ~`LEC_WR_MASK) == 32'h0000_0000)
  ) else $error("reserved bit read as one");

  a_cold_reset_marked: assert property (
    cold_rst |=> ((ctrl_r & `LEC_COLD_MASK) == (`LEC_RESET_VAL & `LEC_COLD_MASK))
  ) else $error("marked bits not at default after pin reset");

  a_eeprom_idle_load: assert property (
    (ee_hit && !cold_rst) |=> (ctrl_r[`LEC_BIT_IDLE] == $past(eeprom_word_in[`LEC_EE_BIT]))
  ) else $error("idle enable not loaded from eeprom");

  a_retries_zero_sf: assert property (
    retries_zero_in |-> (async_transmit_sf_out
                         && (async_transmit_start_out == async_transmit_pkt_done_in))
  ) else $error("zero retries did not force store and forward");

  a_retry_sf: assert property (
    (async_transmit_retry_in && !async_transmit_pkt_done_in) |-> !async_transmit_start_out
  ) else $error("retry started before packet was complete");

  a_underrun_sticks: assert property (
    async_transmit_underrun_in |=> async_transmit_sf_out [*8]
  ) else $error("store and forward dropped after underrun");

  a_sf_waits_eop: assert property (
    (ctrl_r[`LEC_THR_HI:`LEC_THR_LO] == `LEC_THR_SF && !async_transmit_pkt_done_in)
    |-> !async_transmit_start_out
  ) else $error("2K threshold started without end of packet");

  a_thresh_start: assert property (
    (!async_transmit_sf_out && ctrl_r[`LEC_THR_HI:`LEC_THR_LO] == 2'h3
     && async_transmit_fill_in >= `LEC_THR_BYTES_512) |-> async_transmit_start_out
  ) else $error("512 byte threshold did not start");

  a_thresh_default: assert property (
    (!async_transmit_sf_out && ctrl_r[`LEC_THR_HI:`LEC_THR_LO] == 2'h1
     && async_transmit_fill_in < `LEC_THR_BYTES_17 && !async_transmit_pkt_done_in)
    |-> !async_transmit_start_out
  ) else $error("1.7K threshold started early");

  a_initial_until_ur: assert property (
    (ctrl_r[`LEC_THR_HI:`LEC_THR_LO] != `LEC_THR_SF && !retries_zero_in
     && !async_transmit_retry_in && !async_transmit_underrun_in && !async_transmit_sf_out)
    |-> ##1 ($stable(ctrl_r) && !async_transmit_underrun_in && !async_transmit_retry_in
             && !retries_zero_in) |-> !async_transmit_sf_out
  ) else $error("threshold dropped without an underrun");

  a_mpeg_stamp: assert property (
    mpeg_match |=> mpeg_stamp_apply_out
  ) else $error("mpeg stamp not applied");

  a_mpeg_no_stamp: assert property (
    (iso_hdr_in.valid && iso_hdr_in.tag != `LEC_MPEG_TAG) |=> !mpeg_stamp_apply_out
  ) else $error("mpeg stamp applied to wrong tag");

  a_dv_stamp: assert property (
    (!ctrl_r[`LEC_BIT_DV] || !iso_hdr_in.valid) |=> !dv_stamp_apply_out
  ) else $error("dv stamp applied while off");

  a_prio_request: assert property (
    async_req_in |=> (arb_priority_req_out == $past(ctrl_r[`LEC_BIT_PRIO])) && !(arb_priority_req_out
                     && arb_fair_req_out)
  ) else $error("request took wrong arbitration");

  a_accel_notice: assert property (
    (reg_req_in.wr && (cfg_hit || set_hit) && wbits[`LEC_BIT_ACCEL] && !cold_rst)
    |=> phy_accel_notice_out
  ) else $error("acceleration notice missing");

  a_idle_turnaround: assert property (
    (turn_state == link_enh_pkg::PHY_OWNS && link_req_ctl_in
     && phy_link_ctl_lines_in == `LEC_CTL_GRANT && ctrl_r[`LEC_BIT_IDLE])
    |=> phy_link_ctl_lines_oe_b_out ##1 !phy_link_ctl_lines_oe_b_out
  ) else $error("idle cycle not inserted");

  a_direct_handover: assert property (
    (turn_state == link_enh_pkg::PHY_OWNS && link_req_ctl_in
     && phy_link_ctl_lines_in == `LEC_CTL_GRANT && !ctrl_r[`LEC_BIT_IDLE])
    |=> (!phy_link_ctl_lines_oe_b_out && !phy_link_data_oe_b_out)
  ) else $error("link did not take lines after grant");

  a_no_drive_ungranted: assert property (
    (turn_state == link_enh_pkg::PHY_OWNS && phy_link_ctl_lines_in != `LEC_CTL_GRANT)
    |=> phy_link_ctl_lines_oe_b_out
  ) else $error("link drove lines without grant");

  a_rvalid_pulse: assert property (
    !reg_req_in.rd |=> !reg_rvalid_out
  ) else $error("read valid without a read");

  a_unmapped_read_zero: assert property (
    (reg_req_in.rd && !mapped) |=> (reg_rvalid_out && reg_rdata_out == 32'h0000_0000)
  ) else $error("unmapped read returned data");

  a_unmapped_write_kept: assert property (
    (reg_req_in.wr && !mapped && !ee_hit && !cold_rst)
    |=> (ctrl_r == $past(ctrl_r))
  ) else $error("unmapped write changed register");

  a_cfg_plain_write: assert property (
    (reg_req_in.wr && cfg_hit && !ee_hit && !cold_rst)
    |=> (ctrl_r == $past(wbits))
  ) else $error("config alias write not taken");

  a_dv_stamp_on: assert property (
    dv_match |=> dv_stamp_apply_out
  ) else $error("dv stamp not applied");

  a_release_to_phy: assert property (
    (turn_state == link_enh_pkg::LINK_DRIVES && link_release_in)
    |=> (phy_link_ctl_lines_oe_b_out && phy_link_data_oe_b_out)
  ) else $error("link kept lines after release");
endmodule

// ---- testbench/link_enhancement_control_tb.sv ----
// Purpose: self-checking bench for the link enhancement control
// Assumes: phy model on the far side
// Notes: inputs change on the falling edge
`timescale 1ns/1ns
`include "link_enh_defines.svh"
module link_enhancement_control_tb;
  logic                   clk = 0, rst_b = 0, fr_b = 1, gr_b = 1, slow = 0, uk = 0;
  link_enh_pkg::reg_req_s rq = '0;
  link_enh_pkg::iso_hdr_s ih = '0;
  link_enh_pkg::fill_t    fill = '0;
  logic                   ee_p = 0, ee_v = 0, rz = 0, rt = 0, ur = 0, done = 0;
  logic                   areq = 0, lreq = 0, lrel = 0;
  logic [7:0]             ee_a = '0;
  logic [15:0]            ee_w = '0;
  logic [1:0]             ctx = '0, cw, co;
  logic [8:0]             dtx = '0, dw, dout, drx;
  logic [31:0]            rdata, v, m = 32'h1000, seed = 32'h9f7a;
  logic                   rv, sf, st, pd, mp, dv, pri, fair, acc, coe, doe;
  logic [11:0]            ft [8] = '{12'h1ff, 12'h200, 12'h3ff, 12'h400, 12'h6cc, 12'h6cd, 12'hfff, 12'h0};
  int                     n_fail = 0, cmp_count = 0, n;
  initial forever #50 clk = ~clk;
  link_enhancement_control i_dut (.clk_in(clk), .rst_b_in(rst_b), .fundamental_reset_b_in(fr_b),
    .global_reset_pin_b_in(gr_b), .reg_req_in(rq), .reg_rdata_out(rdata), .reg_rvalid_out(rv),
    .eeprom_present_in(ee_p), .eeprom_word_valid_in(ee_v), .eeprom_word_addr_in(ee_a),
    .eeprom_word_in(ee_w), .retries_zero_in(rz), .async_transmit_retry_in(rt),
    .async_transmit_underrun_in(ur), .async_transmit_fill_in(fill),
    .async_transmit_pkt_done_in(done), .async_transmit_sf_out(sf), .async_transmit_start_out(st),
    .async_pipeline_disable_out(pd), .iso_hdr_in(ih), .mpeg_stamp_apply_out(mp),
    .dv_stamp_apply_out(dv), .async_req_in(areq), .arb_priority_req_out(pri),
    .arb_fair_req_out(fair), .phy_accel_notice_out(acc), .link_req_ctl_in(lreq),
    .link_release_in(lrel), .ctl_tx_in(ctx), .data_tx_in(dtx), .phy_link_ctl_lines_in(cw),
    .phy_link_ctl_lines_out(co), .phy_link_ctl_lines_oe_b_out(coe), .phy_link_data_in(dw),
    .phy_link_data_out(dout), .phy_link_data_oe_b_out(doe), .phy_link_data_rx_out(drx));
  phy_model i_phy (.clk_in(clk), .rst_b_in(rst_b), .slow_in(slow), .link_req_in(lreq),
    .link_oe_b_in(coe), .link_ctl_in(co), .link_data_in(dout), .ctl_wire_out(cw),
    .data_wire_out(dw));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic acc_reg(input logic c, w, input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    rq = '{c, w, !w, a, d};
    @(negedge clk);
    rq = '0;
    if (!w) chk(rv ? rdata : 32'hdead, d);
  endtask
  task automatic wr(input logic c, input logic [11:0] a, input logic [31:0] d);
    acc_reg(c, 1, a, d);
    if (c) m = d & `LEC_WR_MASK;
    else if (a == `LEC_SET_OFS) m |= d & `LEC_WR_MASK;
    else if (a == `LEC_CLR_OFS) m &= ~(d & `LEC_WR_MASK);
    chk({acc, pd}, {m[1], m[15]});
  endtask
  task automatic gate_chk();
    int th;
    logic s;
    th = m[13:12] == 2'h1 ? 1741 : m[13:12] == 2'h2 ? 1024 : 512;
    s = m[13:12] == 2'h0 || rz || rt || uk;
    #1;
    chk({sf, st}, {s, done || (!s && fill >= th)});
  endtask
  task automatic bound(input int k);
    if (k >= 20) begin
      n_fail++;
      wrap_up();
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_b = 1;
    acc_reg(1, 0, `LEC_CFG_OFS, m);
    // bits set before link power status
    for (int i = 0; i < 9; i++) begin
      v = rnd();
      wr(i % 3 == 0, i % 3 == 0 ? `LEC_CFG_OFS : i % 3 == 1 ? `LEC_SET_OFS : `LEC_CLR_OFS, v);
      acc_reg(0, 0, i % 2 ? `LEC_SET_OFS : `LEC_CLR_OFS, m);
    end
    acc_reg(0, 1, 12'ha90, 32'hffff_ffff);
    acc_reg(0, 0, 12'ha90, 32'h0);
    acc_reg(1, 0, `LEC_CFG_OFS, m);
    for (int t = 0; t < 4; t++) begin
      wr(1, `LEC_CFG_OFS, 32'(t) << 12);
      foreach (ft[k]) begin
        @(negedge clk);
        fill = ft[k] | 12'(rnd() & 32'h0);
        done = k == 7;
        gate_chk();
      end
    end
    done = 0;
    fill = 12'hfff;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      {rz, rt, ur} = 3'b100 >> k;
      uk |= ur;
      gate_chk();
    end
    for (int e = 0; e < 2; e++) begin
      wr(1, `LEC_CFG_OFS, e ? 32'h0500 : 32'h0080);
      for (int k = 0; k < 12; k++) begin
        @(negedge clk);
        ih = '{1'b1, 2'(k), k < 4 ? 6'h10 : k < 8 ? 6'h00 : 6'h21};
        areq = k[0];
        @(negedge clk);
        ih = '0;
        areq = 0;
        chk({mp, dv}, {m[10] && k == 1, m[8] && k >= 4 && k < 8});
        chk({pri, fair}, {m[7] && k[0], !m[7] && k[0]});
      end
    end
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      ee_p = k != 2;
      ee_v = 1;
      ee_a = k == 1 ? 8'h04 : 8'h05;
      ee_w = 16'(rnd()) & 16'hfffb | (k == 0 ? 16'h4 : 16'h0);
      @(negedge clk);
      ee_v = 0;
      if (ee_p && ee_a == 8'h05) m[2] = ee_w[2];
      acc_reg(0, 0, `LEC_SET_OFS, m);
    end
    for (int i = 0; i < 2; i++) begin
      wr(0, i ? `LEC_SET_OFS : `LEC_CLR_OFS, 32'h4);
      @(negedge clk);
      slow = i;
      lreq = 1;
      for (n = 0; cw !== 2'h3 && n < 20; n++) @(negedge clk);
      bound(n);
      chk(coe, 1);
      for (n = 0; coe !== 1'b0 && n < 20; n++) @(negedge clk);
      bound(n);
      chk(n, 1 + i);
      ctx = 2'(rnd());
      dtx = 9'(rnd());
      v = 32'(dw);
      @(negedge clk);
      chk({co, dout, doe, drx}, {ctx, dtx, 1'b0, v[8:0]});
      lreq = 0;
      lrel = 1;
      @(negedge clk);
      lrel = 0;
      @(negedge clk);
      chk({coe, doe}, 2'h3);
    end
    for (int p = 0; p < 2; p++) begin
      wr(1, `LEC_CFG_OFS, 32'hffff);
      @(negedge clk);
      {fr_b, gr_b} = p ? 2'b10 : 2'b01;
      repeat (4) @(negedge clk);
      {fr_b, gr_b} = 2'b11;
      repeat (4) @(negedge clk);
      m &= ~`LEC_COLD_MASK;
      acc_reg(1, 0, `LEC_CFG_OFS, m);
    end
    wrap_up();
  end
endmodule

// ---- testbench/phy_model.sv ----
// Purpose: behavioural phy on the control and data lines
// Assumes: same clock as the link
// Notes: data lines carry a moving pattern while the phy owns them
`timescale 1ns/1ns
module phy_model (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       slow_in,
  input  wire logic       link_req_in,
  input  wire logic       link_oe_b_in,
  input  wire logic [1:0] link_ctl_in,
  input  wire logic [8:0] link_data_in,
  output logic      [1:0] ctl_wire_out,
  output logic      [8:0] data_wire_out
);
  logic [1:0] ctl_r;
  logic       seen_r;
  logic [8:0] pat_r;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ctl_r <= 2'h0;
      seen_r <= 1'b0;
      pat_r <= 9'h0;
    end else begin
      pat_r <= pat_r + 9'h1b;
      seen_r <= link_req_in && link_oe_b_in;
      ctl_r <= (link_req_in && link_oe_b_in && (seen_r || !slow_in)) ? 2'h3 : 2'h0;
    end
  end
  assign ctl_wire_out  = link_oe_b_in ? ctl_r : link_ctl_in;
  assign data_wire_out = link_oe_b_in ? pat_r : link_data_in;
endmodule
